// ---- mbs_defs.svh ----
// Constants for the motor bypass sequencer: mode codes, field layout and timing.
// Assumes a single 200 MHz control clock shared by both ends.
`ifndef MBS_DEFS_SVH
`define MBS_DEFS_SVH

`define MBS_CLK_MHZ 200
`define MBS_MODE_OVERLAP 2'h1
`define MBS_MODE_NO_OVERLAP 2'h2
`define MBS_MODE_UNSYNC 2'h3
`define MBS_SPEED_W 16
`define MBS_FB_CONV_IDX 0
`define MBS_FB_LINE_IDX 1
`define MBS_DEEXC_US 500
`define MBS_EXC_US 500
`define MBS_DEBYPASS_US 1000

`endif

// ---- mbs_pkg.sv ----
// Types shared by both ends of the motor bypass sequencer.
// Assumes mbs_defs.svh is on the include path.
`include "mbs_defs.svh"
package mbs_pkg;
  typedef logic [1:0] mbs_mode_t;
  typedef logic [`MBS_SPEED_W-1:0] mbs_speed_t;
  // Gray order as listed here; 3'b100 is illegal
  typedef enum logic [2:0] {
    MBS_CONV = 3'h0,
    MBS_SYNC = 3'h1,
    MBS_OPEN_FIRST = 3'h3,
    MBS_WAIT = 3'h2,
    MBS_CLOSE = 3'h6,
    MBS_OPEN_SRC = 3'h7,
    MBS_ON_LINE = 3'h5
  } mbs_state_e;
endpackage

// ---- mbs_if.sv ----
// Link between the bypass sequencer and the plant-side end.
// Both ends run on the same clock; no pin crossing happens on this link.
`timescale 1ns/1ps
interface mbs_if;
  import mbs_pkg::*;
  mbs_mode_t bypass_mode_select;
  logic trigger_by_command;
  logic trigger_by_speed;
  logic bypass_command;
  logic on_cmd;
  logic coast_stop_n;
  logic fast_stop_n;
  mbs_speed_t ramp_input_setpoint;
  mbs_speed_t bypass_speed_threshold;
  logic sync_achieved_flag;
  logic converter_feedback;
  logic line_contactor_feedback;
  logic converter_contactor_close;
  logic line_contactor_close_cmd;
  logic sync_request_bit;
  logic pulse_enable;

  modport dev (
    input bypass_mode_select, trigger_by_command, trigger_by_speed, bypass_command, on_cmd,
    input coast_stop_n, fast_stop_n, ramp_input_setpoint, bypass_speed_threshold,
    input sync_achieved_flag, converter_feedback, line_contactor_feedback,
    output converter_contactor_close, line_contactor_close_cmd, sync_request_bit, pulse_enable
  );
  modport plant (
    output bypass_mode_select, trigger_by_command, trigger_by_speed, bypass_command, on_cmd,
    output coast_stop_n, fast_stop_n, ramp_input_setpoint, bypass_speed_threshold,
    output sync_achieved_flag, converter_feedback, line_contactor_feedback,
    input converter_contactor_close, line_contactor_close_cmd, sync_request_bit, pulse_enable
  );
endinterface

// ---- mbs_sequencer.sv ----
// Bypass sequencer: moves the motor between converter feed and line feed.
// Assumes the plant end delivers settled, clock-synchronous feedback and settings.
`timescale 1ns/1ps
`include "mbs_defs.svh"

// Summary of operation
// R01 - Mode 1 overlap, 2 no overlap, 3 unsynchronized
// R02 - Overlap mode closes both contactors briefly
// R03 - Synchronized modes start only from command
// R04 - Start converter-fed; command sets sync request
// R05 - Sync request while running starts synchronization
// R06 - Sync reported closes the line contactor
// R07 - Line closed: open converter, inhibit pulses, standby
// R08 - On removed in hot standby gives basic standby
// R09 - Retrieval: sync request first, then pulse enable
// R10 - Retrieval: close converter, then open line
// R11 - No overlap: line closes after converter opens
// R12 - Operator sets phase lead for no overlap
// R13 - Unsync to line: inhibit, open, de-excite, close
// R14 - Unsync retrieve: open line, excite, close, catch
// R15 - Plant interlocks contactors in unsync mode
// R16 - Flying restart enabled in unsync mode
// R17 - Command trigger; return after debypass delay
// R18 - Speed trigger needs setpoint above threshold
// R19 - Revert when ramp input setpoint drops below
// R20 - Internal sync source, enable from request
// R21 - Feedback index 0 converter, 1 line
// R22 - Fast or coast stop withdrawn drops bypass
// R23 - Hold step until expected feedback arrives
module mbs_sequencer #(
  parameter int unsigned DEEXC_CYC = `MBS_DEEXC_US * `MBS_CLK_MHZ,
  parameter int unsigned EXC_CYC = `MBS_EXC_US * `MBS_CLK_MHZ,
  parameter int unsigned DEBYPASS_CYC = `MBS_DEBYPASS_US * `MBS_CLK_MHZ
) (
  input wire logic clock_in,
  input wire logic rst_in,
  mbs_if.dev link,
  output logic bypass_active_out,
  output logic hot_standby_out,
  output logic basic_standby_out
);
  import mbs_pkg::*;

  typedef struct packed {
    mbs_state_e st;
    logic to_line;
    logic [31:0] timer;
    logic conv;
    logic line;
    logic sync;
    logic pulse;
    logic active;
    logic hot;
    logic basic;
  } mbs_seq_s;

  mbs_seq_s state_q;
  mbs_seq_s state_d;
  logic stops_ok;
  logic sync_mode;
  logic valid_mode;
  logic speed_ok;
  logic want;
  logic src_fb;
  logic tgt_fb;

  // Speed trigger only counts in unsynchronized mode
  always_comb begin
    stops_ok = link.coast_stop_n && link.fast_stop_n;
    valid_mode = (link.bypass_mode_select == `MBS_MODE_OVERLAP) ||
                 (link.bypass_mode_select == `MBS_MODE_NO_OVERLAP) ||
                 (link.bypass_mode_select == `MBS_MODE_UNSYNC); // [R01]
    sync_mode = (link.bypass_mode_select != `MBS_MODE_UNSYNC);
    // Setpoint, not actual speed, so bypass does not re-arm at once after return
    speed_ok = link.ramp_input_setpoint > link.bypass_speed_threshold; // [R18] [R19]
    want = stops_ok && valid_mode &&
           ((link.trigger_by_command && link.bypass_command) ||
            (link.trigger_by_speed && !sync_mode && speed_ok)); // [R03] [R17]
  end

  // Source is the contactor being left, target the one being taken
  always_comb begin
    src_fb = state_q.to_line ? link.converter_feedback : link.line_contactor_feedback;
    tgt_fb = state_q.to_line ? link.line_contactor_feedback : link.converter_feedback;
  end

  always_comb begin
    state_d = state_q;
    unique case (state_q.st)
      MBS_CONV: begin
        state_d.timer = '0;
        state_d.line = 1'b0;
        state_d.sync = 1'b0;
        state_d.active = 1'b0;
        state_d.to_line = 1'b1;
        // Never close the converter side onto a closed line contactor
        state_d.conv = stops_ok && link.on_cmd && !link.line_contactor_feedback; // [R23]
        state_d.pulse = state_d.conv && link.converter_feedback;
        if (want && link.converter_feedback && !link.line_contactor_feedback) begin // [R04]
          state_d.active = 1'b1;
          if (sync_mode) begin
            state_d.sync = 1'b1; // [R04]
            state_d.st = MBS_SYNC; // [R05]
          end else begin
            state_d.pulse = 1'b0; // [R13]
            state_d.conv = 1'b0;
            state_d.st = MBS_OPEN_FIRST;
          end
        end
      end
      MBS_SYNC: begin
        // Request leads pulse enable by one cycle on retrieval
        state_d.pulse = state_q.to_line ? state_q.pulse : state_q.sync; // [R09]
        if (link.sync_achieved_flag && state_q.pulse) begin
          state_d.sync = 1'b0;
          if (link.bypass_mode_select == `MBS_MODE_NO_OVERLAP) begin
            if (state_q.to_line) begin
              state_d.conv = 1'b0; // [R11]
              state_d.pulse = 1'b0;
            end else begin
              state_d.line = 1'b0;
            end
            state_d.st = MBS_OPEN_FIRST;
          end else begin
            if (state_q.to_line) begin
              state_d.line = 1'b1; // [R06] [R02]
            end else begin
              state_d.conv = 1'b1; // [R10] [R02]
            end
            state_d.st = MBS_CLOSE;
          end
        end
      end
      MBS_OPEN_FIRST: begin
        if (!src_fb) begin // [R23]
          if (sync_mode) begin
            if (state_q.to_line) begin
              state_d.line = 1'b1; // [R11]
            end else begin
              state_d.conv = 1'b1;
            end
            state_d.st = MBS_CLOSE;
          end else begin
            state_d.timer = '0;
            state_d.st = MBS_WAIT;
          end
        end
      end
      MBS_WAIT: begin
        state_d.timer = state_q.timer + 32'h1;
        if (state_q.timer >= (state_q.to_line ? DEEXC_CYC - 1 : EXC_CYC - 1)) begin // [R13] [R14]
          if (state_q.to_line) begin
            state_d.line = 1'b1;
          end else begin
            state_d.conv = 1'b1;
          end
          state_d.st = MBS_CLOSE;
        end
      end
      MBS_CLOSE: begin
        if (tgt_fb) begin // [R23]
          if (src_fb) begin
            if (state_q.to_line) begin
              state_d.conv = 1'b0; // [R07]
              state_d.pulse = 1'b0;
            end else begin
              state_d.line = 1'b0; // [R10]
            end
            state_d.st = MBS_OPEN_SRC;
          end else if (state_q.to_line) begin
            // Debypass count must start fresh, not from the de-excitation count
            state_d.timer = '0; // [R17]
            state_d.st = MBS_ON_LINE; // [R07]
          end else begin
            state_d.pulse = 1'b1; // [R14]
            state_d.st = MBS_CONV;
          end
        end
      end
      MBS_OPEN_SRC: begin
        if (!src_fb) begin // [R23]
          if (state_q.to_line) begin
            state_d.timer = '0;
            state_d.st = MBS_ON_LINE;
          end else begin
            state_d.pulse = 1'b1;
            state_d.st = MBS_CONV;
          end
        end
      end
      MBS_ON_LINE: begin
        state_d.hot = link.on_cmd; // [R07] [R08]
        state_d.basic = !link.on_cmd; // [R08]
        // Debypass delay applies to a withdrawn command, a low setpoint acts at once
        if (want) begin
          state_d.timer = '0;
        end else if (state_q.timer < DEBYPASS_CYC - 1 && link.trigger_by_command &&
                     !(link.trigger_by_speed && !speed_ok)) begin
          state_d.timer = state_q.timer + 32'h1; // [R17]
        end else begin
          state_d.hot = 1'b0;
          state_d.basic = 1'b0;
          state_d.to_line = 1'b0;
          if (sync_mode) begin
            state_d.sync = 1'b1; // [R09]
            state_d.st = MBS_SYNC;
          end else begin
            state_d.line = 1'b0; // [R14]
            state_d.st = MBS_OPEN_FIRST;
          end
        end
      end
      default: begin
        state_d.st = MBS_CONV;
      end
    endcase
    // Stop withdrawn overrides every step: both contactors open, no pulses
    if (!stops_ok && state_q.st != MBS_CONV) begin
      state_d = '0; // [R22]
      state_d.st = MBS_CONV;
    end
  end

  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      state_q <= '0;
    end else begin
      state_q <= state_d;
    end
  end

  assign link.converter_contactor_close = state_q.conv;
  assign link.line_contactor_close_cmd = state_q.line;
  assign link.sync_request_bit = state_q.sync;
  assign link.pulse_enable = state_q.pulse;
  assign bypass_active_out = state_q.active;
  assign hot_standby_out = state_q.hot;
  assign basic_standby_out = state_q.basic;
endmodule

// ---- mbs_plant_end.sv ----
// Plant-side end: automation settings, contactor interlock, synchronizer wiring.
// Assumes feedback pins and the synchronizer flag arrive asynchronously.
`timescale 1ns/1ps
`include "mbs_defs.svh"
module mbs_plant_end (
  input wire logic clock_in,
  input wire logic rst_in,
  mbs_if.plant link,
  input wire logic [1:0] bypass_mode_select_in,
  input wire logic trigger_by_command_in,
  input wire logic trigger_by_speed_in,
  input wire logic bypass_command_in,
  input wire logic on_cmd_in,
  input wire logic coast_stop_n_in,
  input wire logic fast_stop_n_in,
  input wire mbs_pkg::mbs_speed_t ramp_input_setpoint_in,
  input wire mbs_pkg::mbs_speed_t bypass_speed_threshold_in,
  input wire mbs_pkg::mbs_speed_t phase_lead_in,
  input wire logic [1:0] contactor_feedback_source_in,
  input wire logic sync_achieved_in,
  output logic converter_coil_out,
  output logic line_coil_out,
  output logic sync_enable_out,
  output logic sync_voltage_source_select_out,
  output logic flying_restart_select_out,
  output mbs_pkg::mbs_speed_t sync_phase_setpoint_out
);
  import mbs_pkg::*;

  typedef struct packed {
    logic [2:0] fb_c;
    logic [2:0] fb_l;
    logic [2:0] fb_s;
    logic conv_fb;
    logic line_fb;
    logic sync_fb;
    logic conv_coil;
    logic line_coil;
    logic sync_en;
    logic src_int;
    logic flying;
    mbs_speed_t phase;
  } mbs_plant_s;

  mbs_plant_s state_q;
  mbs_plant_s state_d;
  logic unsync;

  always_comb begin
    state_d = state_q;
    unsync = bypass_mode_select_in == `MBS_MODE_UNSYNC;
    // Three-stage capture; a change counts once stages two and three agree
    state_d.fb_c = {state_q.fb_c[1:0], contactor_feedback_source_in[`MBS_FB_CONV_IDX]}; // [R21]
    state_d.fb_l = {state_q.fb_l[1:0], contactor_feedback_source_in[`MBS_FB_LINE_IDX]}; // [R21]
    state_d.fb_s = {state_q.fb_s[1:0], sync_achieved_in};
    if (state_q.fb_c[2] == state_q.fb_c[1]) begin
      state_d.conv_fb = state_q.fb_c[2];
    end
    if (state_q.fb_l[2] == state_q.fb_l[1]) begin
      state_d.line_fb = state_q.fb_l[2];
    end
    if (state_q.fb_s[2] == state_q.fb_s[1]) begin
      state_d.sync_fb = state_q.fb_s[2];
    end
    // Hard interlock in unsync mode: a coil closes only with the other open
    state_d.line_coil = link.line_contactor_close_cmd &&
                        !(unsync && (state_q.conv_coil || state_q.conv_fb)); // [R15]
    // Line coil decided first, so both coils can never rise on one edge
    state_d.conv_coil = link.converter_contactor_close &&
                        !(unsync && (state_d.line_coil || state_q.line_coil ||
                                     state_q.line_fb)); // [R15]
    state_d.sync_en = link.sync_request_bit && !unsync; // [R20]
    state_d.src_int = !unsync; // [R20]
    state_d.flying = unsync; // [R16]
    state_d.phase = (bypass_mode_select_in == `MBS_MODE_NO_OVERLAP) ? phase_lead_in : '0; // [R12]
  end

  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      state_q <= '0;
    end else begin
      state_q <= state_d;
    end
  end

  assign link.bypass_mode_select = bypass_mode_select_in;
  assign link.trigger_by_command = trigger_by_command_in;
  assign link.trigger_by_speed = trigger_by_speed_in;
  assign link.bypass_command = bypass_command_in;
  assign link.on_cmd = on_cmd_in;
  assign link.coast_stop_n = coast_stop_n_in;
  assign link.fast_stop_n = fast_stop_n_in;
  assign link.ramp_input_setpoint = ramp_input_setpoint_in;
  assign link.bypass_speed_threshold = bypass_speed_threshold_in;
  assign link.sync_achieved_flag = state_q.sync_fb;
  assign link.converter_feedback = state_q.conv_fb;
  assign link.line_contactor_feedback = state_q.line_fb;
  assign converter_coil_out = state_q.conv_coil;
  assign line_coil_out = state_q.line_coil;
  assign sync_enable_out = state_q.sync_en;
  assign sync_voltage_source_select_out = state_q.src_int;
  assign flying_restart_select_out = state_q.flying;
  assign sync_phase_setpoint_out = state_q.phase;
endmodule

// ---- mbs_chk.sv ----
// Checker for the link between the bypass sequencer and the plant end.
// Assumes one clock domain and the link signals wired in by name.
`timescale 1ns/1ps
module mbs_chk #(
  parameter int unsigned DEEXC_CYC = 12,
  parameter int unsigned EXC_CYC = 12
) (
  input wire logic clock_in,
  input wire logic rst_in,
  input wire mbs_pkg::mbs_mode_t bypass_mode_select,
  input wire logic coast_stop_n,
  input wire logic fast_stop_n,
  input wire logic sync_achieved_flag,
  input wire logic converter_feedback,
  input wire logic line_contactor_feedback,
  input wire logic converter_contactor_close,
  input wire logic line_contactor_close_cmd,
  input wire logic sync_request_bit,
  input wire logic pulse_enable
);
  import mbs_pkg::*;
  logic [15:0] idle_q;
  logic was_line_q;
  wire logic stops = coast_stop_n && fast_stop_n;
  wire logic sync_mode = bypass_mode_select == 2'h1 || bypass_mode_select == 2'h2;
  wire logic idle = !(converter_feedback || line_contactor_feedback ||
                      converter_contactor_close || line_contactor_close_cmd);

  // Idle time is counted only with both coils and both feedbacks off
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      idle_q <= 16'h0;
      was_line_q <= 1'b0;
    end else begin
      idle_q <= idle ? idle_q + 16'h1 : 16'h0;
      was_line_q <= line_contactor_feedback | (was_line_q & ~converter_feedback);
    end
  end

  default clocking cb @(posedge clock_in); endclocking
  default disable iff (rst_in);

  sync_mode_only_a: assert property (
    $rose(sync_request_bit) |-> sync_mode) else $error("sync request outside sync mode");
  no_overlap_a: assert property (
    bypass_mode_select != 2'h1 |-> !(converter_contactor_close && line_contactor_close_cmd))
    else $error("both contactors closed outside overlap mode");
  line_close_cause_a: assert property (
    $rose(line_contactor_close_cmd) && bypass_mode_select == 2'h1
    |-> $past(sync_achieved_flag && pulse_enable)) else $error("line closed without sync");
  conv_open_a: assert property (
    $fell(converter_contactor_close) && bypass_mode_select == 2'h1 && $past(stops)
    |-> $past(line_contactor_feedback) && !pulse_enable) else $error("converter opened early");
  pulse_off_a: assert property (
    $fell(converter_contactor_close) |-> !pulse_enable) else $error("pulses on at open");
  deexc_wait_a: assert property (
    $rose(line_contactor_close_cmd) && bypass_mode_select == 2'h3
    |-> idle_q + 16'h4 >= DEEXC_CYC && idle_q <= DEEXC_CYC + 4) else $error("bad de-excite wait");
  exc_wait_a: assert property (
    $rose(converter_contactor_close) && bypass_mode_select == 2'h3 && was_line_q
    |-> idle_q + 16'h4 >= EXC_CYC && idle_q <= EXC_CYC + 4) else $error("bad excite wait");
  sync_drop_a: assert property (
    sync_request_bit && sync_achieved_flag && pulse_enable |=> !sync_request_bit)
    else $error("sync request held after sync");
  retrieve_order_a: assert property (
    $rose(pulse_enable) && line_contactor_feedback && sync_mode |-> sync_request_bit)
    else $error("pulses enabled before sync request");
  stop_drop_a: assert property (
    !stops && (line_contactor_close_cmd || sync_request_bit)
    |=> !(line_contactor_close_cmd || sync_request_bit || converter_contactor_close))
    else $error("bypass kept after stop");
  hold_step_a: assert property (
    line_contactor_close_cmd && !line_contactor_feedback && bypass_mode_select == 2'h1 && stops
    |-> converter_contactor_close) else $error("converter opened before line feedback");

  cover property (bypass_mode_select == 2'h1 && converter_contactor_close &&
                  line_contactor_close_cmd);
  cover property ($rose(line_contactor_close_cmd) && bypass_mode_select == 2'h3);
  cover property (!stops && line_contactor_close_cmd);
endmodule

// ---- tb_motor_bypass_sequencer.sv ----
// Testbench joining both ends of the bypass sequencer over their link.
// Assumes contactors echo their coils a cycle later and a simple synchronizer.
`timescale 1ns/1ps
module tb_motor_bypass_sequencer;
  import mbs_pkg::*;
  localparam int unsigned DEEXC = 12;
  localparam int unsigned EXC = 12;
  localparam int unsigned DEBYP = 16;
  localparam int LIMIT = 20000;
  logic clock_in = 1'b0;
  logic rst_in = 1'b1;
  logic [1:0] mode = 2'h1;
  logic trig_cmd = 1'b1;
  logic trig_speed = 1'b0;
  logic byp_cmd = 1'b0;
  logic on_cmd = 1'b1;
  logic coast_n = 1'b1;
  logic fast_n = 1'b1;
  mbs_speed_t setpoint = 16'h0100;
  logic [1:0] fb = 2'h0;
  logic sync_in = 1'b0;
  logic [7:0] scnt = 8'h0;
  logic both_seen = 1'b0;
  logic sync_seen = 1'b0;
  logic conv_coil, line_coil, sync_en, volt_sel, fly_sel, byp_act, hot, basic;
  mbs_speed_t phase_sp;
  int fails = 0;
  int checks = 0;
  int cyc = 0;
  mbs_if link ();

  mbs_sequencer #(.DEEXC_CYC(DEEXC), .EXC_CYC(EXC), .DEBYPASS_CYC(DEBYP)) u_mbs_sequencer (
    .clock_in(clock_in), .rst_in(rst_in), .link(link.dev), .bypass_active_out(byp_act),
    .hot_standby_out(hot), .basic_standby_out(basic));
  mbs_plant_end u_mbs_plant_end (
    .clock_in(clock_in), .rst_in(rst_in), .link(link.plant), .bypass_mode_select_in(mode),
    .trigger_by_command_in(trig_cmd), .trigger_by_speed_in(trig_speed),
    .bypass_command_in(byp_cmd), .on_cmd_in(on_cmd), .coast_stop_n_in(coast_n),
    .fast_stop_n_in(fast_n), .ramp_input_setpoint_in(setpoint),
    .bypass_speed_threshold_in(16'h0200), .phase_lead_in(16'h0040),
    .contactor_feedback_source_in(fb), .sync_achieved_in(sync_in),
    .converter_coil_out(conv_coil), .line_coil_out(line_coil), .sync_enable_out(sync_en),
    .sync_voltage_source_select_out(volt_sel), .flying_restart_select_out(fly_sel),
    .sync_phase_setpoint_out(phase_sp));
  mbs_chk #(.DEEXC_CYC(DEEXC), .EXC_CYC(EXC)) u_mbs_chk (
    .clock_in(clock_in), .rst_in(rst_in), .bypass_mode_select(link.bypass_mode_select),
    .coast_stop_n(link.coast_stop_n), .fast_stop_n(link.fast_stop_n),
    .sync_achieved_flag(link.sync_achieved_flag), .converter_feedback(link.converter_feedback),
    .line_contactor_feedback(link.line_contactor_feedback),
    .converter_contactor_close(link.converter_contactor_close),
    .line_contactor_close_cmd(link.line_contactor_close_cmd),
    .sync_request_bit(link.sync_request_bit), .pulse_enable(link.pulse_enable));

  initial begin
    forever #2.5 clock_in = ~clock_in;
  end

  // Contactors and synchronizer; sync settles a few cycles after enable
  always @(posedge clock_in) begin
    fb <= {line_coil, conv_coil};
    scnt <= sync_en ? scnt + 8'h1 : 8'h0;
    sync_in <= scnt >= 8'h6;
    if (link.converter_contactor_close && link.line_contactor_close_cmd) both_seen <= 1'b1;
    if (link.sync_request_bit) sync_seen <= 1'b1;
  end

  always @(posedge clock_in) begin
    cyc++;
    if (cyc == LIMIT) begin
      fails++;
      give_verdict();
    end
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge clock_in);
  endtask

  function automatic logic probe(input int sel);
    case (sel)
      0: return hot === 1'b1;
      1: return basic === 1'b1;
      default: return conv_coil === 1'b1 && line_coil === 1'b0 && fb === 2'h1 && byp_act === 1'b0;
    endcase
  endfunction

  // Feedback steps have no timeout in the design, so the wait is bounded here
  task automatic wait_for(input int sel);
    int n;
    n = 0;
    while (probe(sel) !== 1'b1 && n < 400) begin
      @(posedge clock_in);
      #1;
      n++;
    end
    check(probe(sel), 1'b1);
  endtask

  task automatic give_verdict();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  initial begin
    step(6);
    rst_in <= 1'b0;
    wait_for(2);
    for (int m = 1; m <= 3; m++) begin
      @(posedge clock_in);
      mode <= 2'(m);
      both_seen <= 1'b0;
      sync_seen <= 1'b0;
      byp_cmd <= 1'b1;
      wait_for(0);
      check({link.converter_contactor_close, link.line_contactor_close_cmd, link.pulse_enable}, 3'h2);
      check(both_seen, m == 1);
      check(sync_seen, m != 3);
      check(phase_sp, m == 2 ? 16'h0040 : 16'h0);
      check({volt_sel, fly_sel}, m == 3 ? 2'h1 : 2'h2);
      @(posedge clock_in);
      on_cmd <= 1'b0;
      wait_for(1);
      @(posedge clock_in);
      on_cmd <= 1'b1;
      wait_for(0);
      @(posedge clock_in);
      byp_cmd <= 1'b0;
      step(DEBYP - 4);
      #1;
      check(hot, 1'b1);
      step(3);
      #1;
      check(hot, 1'b1);
      step(1);
      #1;
      check(hot, 1'b0);
      wait_for(2);
      check(link.pulse_enable, 1'b1);
      check(both_seen, m == 1);
    end
    // Speed trigger refused in mode 1, any trigger in mode 0
    @(posedge clock_in);
    mode <= 2'h1;
    trig_cmd <= 1'b0;
    trig_speed <= 1'b1;
    setpoint <= 16'h0300;
    step(40);
    #1;
    check(byp_act, 1'b0);
    @(posedge clock_in);
    mode <= 2'h0;
    trig_cmd <= 1'b1;
    byp_cmd <= 1'b1;
    step(40);
    #1;
    check({byp_act, link.sync_request_bit}, 2'h0);
    // Threshold equal is not above it
    @(posedge clock_in);
    mode <= 2'h3;
    trig_cmd <= 1'b0;
    byp_cmd <= 1'b0;
    setpoint <= 16'h0200;
    step(40);
    #1;
    check(byp_act, 1'b0);
    @(posedge clock_in);
    setpoint <= 16'h0201;
    wait_for(0);
    @(posedge clock_in);
    setpoint <= 16'h0200;
    wait_for(2);
    for (int s = 0; s < 2; s++) begin
      @(posedge clock_in);
      mode <= 2'h1;
      trig_speed <= 1'b0;
      trig_cmd <= 1'b1;
      byp_cmd <= 1'b1;
      wait_for(0);
      @(posedge clock_in);
      coast_n <= s[0];
      fast_n <= !s[0];
      step(2);
      #1;
      check({link.converter_contactor_close, link.line_contactor_close_cmd, byp_act}, 3'h0);
      @(posedge clock_in);
      coast_n <= 1'b1;
      fast_n <= 1'b1;
      byp_cmd <= 1'b0;
      wait_for(2);
    end
    give_verdict();
  end
endmodule
